/* include/pscp_pkg.sv */
// Purpose: Shared constants and types of the passive serial configuration port.
// Assumes: 125 MHz system clock, APB register access.
// Notes: Long delays are parameters of the top module so that simulation can shorten them.
package pscp_pkg;

  localparam int CLOCK_NS = 8;
  // Power-on reset times, selected by the power-on delay select pin.
  localparam int POR_LONG_MS = 100;
  localparam int POR_SHORT_MS = 12;
  // Longest reset time-out after an error when auto-restart is on.
  localparam int RESTART_TIMEOUT_US = 40;
  // Delay from load complete going high until the user clock is accepted.
  localparam int DONE_TO_USER_CLOCK_NS = 2000;
  localparam int DONE_TO_USER_CLOCK_CYCLES = (DONE_TO_USER_CLOCK_NS + CLOCK_NS - 1) / CLOCK_NS;
  // Internal oscillator of about 10 MHz, derived by dividing the system clock.
  localparam int OSC_PERIOD_NS = 100;
  localparam int OSC_DIV_CYCLES = OSC_PERIOD_NS / CLOCK_NS;
  localparam int INIT_CYCLES = 299;

  // Register byte addresses.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LENGTH = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_BITCNT = 8'h0c;
  // Control field positions and reset values.
  localparam int CTRL_USER_CLK_EN = 0;
  localparam int CTRL_INIT_DONE_EN = 1;
  localparam int CTRL_AUTO_RESTART = 2;
  localparam logic [2:0] CTRL_RESET = 3'h4;
  localparam logic [31:0] LENGTH_RESET = 32'h0000_0100;
  // Status field positions.
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_ERROR = 4;
  localparam int STAT_REMOTE = 5;
  localparam int STAT_SCHEME_OK = 6;
  // Scheme select codes.
  localparam logic [3:0] SCHEME_PLAIN = 4'h2;
  localparam logic [3:0] SCHEME_REMOTE = 4'h6;
  // First byte of every bitstream; any other value is a load error.
  localparam logic [7:0] SYNC_BYTE = 8'ha5;

  typedef enum logic [2:0] {
    ST_POR,
    ST_RESET,
    ST_CONFIG,
    ST_DONE_WAIT,
    ST_INIT_DELAY,
    ST_INIT,
    ST_USER,
    ST_ERROR
  } pscp_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } pscp_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pscp_apb_rsp_t;

  typedef struct packed {
    logic cfg_req_n;
    logic sclk;
    logic sdata;
    logic status_ln;
    logic done_ln;
    logic uclk;
    logic por_sel;
    logic pull_dis_n;
    logic rlu;
    logic [3:0] scheme_select;
  } pscp_pins_t;

endpackage : pscp_pkg

/* src/pscp_config_port.sv */
// Purpose: Device side of a passive serial configuration port with APB control.
// Assumes: Every pin input is asynchronous and passes two flip-flops before use.
// Notes: Open-drain pins are split into output, and an enable that is low while driving.
`timescale 1ns/1ns

// How it works
// - Scheme pins 0010 or 0110 choose loading.
// - Power-on reset 100 ms, or 12 ms.
// - Power-on reset drives status low, I/O tri-stated.
// - Weak pull-ups on unless pull-up disable high; off in power-on reset and user mode.
// - Stages reset, load, init; reset while lines low.
// - Request high releases status, loading begins.
// - Data sampled on each serial clock rise.
// - All data received releases load complete.
// - Internal oscillator default, user clock optional.
// - Internal oscillator supplies all init cycles while user clock is off.
// - Serial clock after loading is ignored.
// - User clock accepted only after done delay.
// - User clock needs 299 cycles to finish.
// - Init complete rises at user mode entry.
// - Init complete released during reset, early load.
// - Option loaded drives init complete low.
// - Error drives status low, auto-restart releases.
module pscp_config_port #(
  parameter int POR_LONG_CYCLES = pscp_pkg::POR_LONG_MS * 1000000 / pscp_pkg::CLOCK_NS,
  parameter int POR_SHORT_CYCLES = pscp_pkg::POR_SHORT_MS * 1000000 / pscp_pkg::CLOCK_NS,
  parameter int RESTART_CYCLES = pscp_pkg::RESTART_TIMEOUT_US * 1000 / pscp_pkg::CLOCK_NS
) (
  input wire logic i_clock, // System clock.
  input wire logic i_srst, // Synchronous reset, high.
  input wire pscp_pkg::pscp_apb_req_t i_apb, // APB request.
  output pscp_pkg::pscp_apb_rsp_t o_apb, // APB answer.
  input wire logic i_config_req_n, // Configuration request, low holds reset.
  input wire logic i_serial_load_clock, // Host serial clock.
  input wire logic i_serial_load_data, // Host serial data.
  input wire logic [3:0] i_scheme_select, // Scheme select pins.
  input wire logic i_remote_local_update_select, // Remote or local update.
  input wire logic i_power_on_delay_select, // High picks the short delay.
  input wire logic i_io_pullup_disable_n, // High turns weak pull-ups off.
  input wire logic i_user_init_clock, // Optional init clock.
  input wire logic i_status_i, // Status line level.
  output logic o_status_o, // Status drive value.
  output logic o_status_oe_n, // Status drive enable, low drives.
  input wire logic i_load_complete_i, // Load complete line level.
  output logic o_load_complete_o, // Load complete drive value.
  output logic o_load_complete_oe_n, // Load complete enable, low drives.
  output logic o_init_complete_o, // Init complete drive value.
  output logic o_init_complete_oe_n, // Init complete enable, low drives.
  output logic o_user_io_hiz, // User I/O tri-stated.
  output logic o_weak_pullup_en, // Weak pull-ups on.
  output logic o_user_mode // Device in user mode.
);
  import pscp_pkg::*;

  typedef struct packed {
    pscp_state_t state;
    // Two synchroniser stages per pin; logic reads only the second.
    pscp_pins_t sync1;
    pscp_pins_t sync2;
    logic sclk_prev;
    logic uclk_prev;
    logic [31:0] cnt;
    logic [7:0] div;
    logic [31:0] bitcnt;
    logic [7:0] shreg;
    logic opt_loaded;
    logic err_flag;
    logic [2:0] ctrl;
    logic [31:0] length;
    logic [31:0] prdata;
    logic pslverr;
  } pscp_regs_t;

  pscp_regs_t q;
  pscp_regs_t d;
  pscp_pins_t pins;
  logic sclk_rise;
  logic uclk_rise;
  logic osc_tick;
  logic init_tick;
  logic scheme_ok;
  logic remote;
  logic [7:0] byte_now;
  logic apb_setup;
  logic apb_write;
  logic [31:0] por_limit;
  logic [31:0] status_word;

  always_comb
  begin
    pins.cfg_req_n = i_config_req_n;
    pins.sclk = i_serial_load_clock;
    pins.sdata = i_serial_load_data;
    pins.status_ln = i_status_i;
    pins.done_ln = i_load_complete_i;
    pins.uclk = i_user_init_clock;
    pins.por_sel = i_power_on_delay_select;
    pins.pull_dis_n = i_io_pullup_disable_n;
    pins.rlu = i_remote_local_update_select;
    pins.scheme_select = i_scheme_select;
  end

  assign sclk_rise = q.sync2.sclk & ~q.sclk_prev;
  assign uclk_rise = q.sync2.uclk & ~q.uclk_prev;
  assign osc_tick = (q.div == 8'(OSC_DIV_CYCLES - 1));
  assign init_tick = q.ctrl[CTRL_USER_CLK_EN] ? uclk_rise : osc_tick;
  assign scheme_ok = (q.sync2.scheme_select == SCHEME_PLAIN) || (q.sync2.scheme_select == SCHEME_REMOTE);
  assign remote = (q.sync2.scheme_select == SCHEME_REMOTE);
  assign byte_now = {q.sync2.sdata, q.shreg[7:1]};
  assign apb_setup = i_apb.psel & ~i_apb.penable;
  assign apb_write = i_apb.psel & i_apb.penable & i_apb.pwrite;
  assign por_limit = q.sync2.por_sel ? 32'(POR_SHORT_CYCLES) : 32'(POR_LONG_CYCLES);

  always_comb
  begin
    status_word = 32'h0;
    status_word[STAT_STATE_LSB +: 3] = q.state;
    status_word[STAT_ERROR] = q.err_flag;
    status_word[STAT_REMOTE] = remote & q.sync2.rlu;
    status_word[STAT_SCHEME_OK] = scheme_ok;
  end

  always_comb
  begin
    d = q;
    // The first stage is read only by the second stage.
    d.sync1 = pins;
    d.sync2 = q.sync1;
    d.sclk_prev = q.sync2.sclk;
    d.uclk_prev = q.sync2.uclk;
    d.div = osc_tick ? 8'h00 : q.div + 8'h01;

    case (q.state)
      ST_POR:
      begin
        // The delay select pin is followed all through the count.
        d.cnt = q.cnt + 32'h1;
        if (q.cnt >= por_limit - 32'h1)
        begin
          d.state = ST_RESET;
          d.cnt = 32'h0;
        end
      end
      ST_RESET:
      begin
        // Counters stay clear until request, status and scheme allow loading.
        d.bitcnt = 32'h0;
        d.shreg = 8'h00;
        d.opt_loaded = 1'b0;
        d.cnt = 32'h0;
        if (q.sync2.cfg_req_n && q.sync2.status_ln && scheme_ok)
        begin
          d.state = ST_CONFIG;
        end
      end
      ST_CONFIG:
      begin
        // Bits arrive low bit first, so each new bit enters at the top.
        if (sclk_rise)
        begin
          d.shreg = byte_now;
          d.bitcnt = q.bitcnt + 32'h1;
          if (q.bitcnt[2:0] == 3'h7)
          begin
            d.opt_loaded = 1'b1;
            if (q.bitcnt[31:3] == 29'h0 && byte_now != SYNC_BYTE)
            begin
              d.state = ST_ERROR;
            end
          end
          if (q.bitcnt + 32'h1 == q.length && d.state == ST_CONFIG)
          begin
            d.state = ST_DONE_WAIT;
          end
        end
      end
      ST_DONE_WAIT:
      begin
        // Initialisation starts once the shared line reads high.
        if (q.sync2.done_ln)
        begin
          d.state = ST_INIT_DELAY;
          d.cnt = 32'h0;
        end
      end
      ST_INIT_DELAY:
      begin
        // User clock edges are not counted until the delay has run out.
        d.cnt = q.cnt + 32'h1;
        if (!q.ctrl[CTRL_USER_CLK_EN] || q.cnt == 32'(DONE_TO_USER_CLOCK_CYCLES - 1))
        begin
          d.state = ST_INIT;
          d.cnt = 32'h0;
        end
      end
      ST_INIT:
      begin
        if (init_tick)
        begin
          d.cnt = q.cnt + 32'h1;
          if (q.cnt == 32'(INIT_CYCLES - 1))
          begin
            d.state = ST_USER;
            d.cnt = 32'h0;
          end
        end
      end
      ST_USER:
      begin
        // Serial clock edges are ignored from here on.
        d.cnt = 32'h0;
      end
      ST_ERROR:
      begin
        if (q.ctrl[CTRL_AUTO_RESTART])
        begin
          d.cnt = q.cnt + 32'h1;
          if (q.cnt == 32'(RESTART_CYCLES - 1))
          begin
            d.state = ST_RESET;
            d.cnt = 32'h0;
          end
        end
        // Without auto-restart only a low request leaves the error stage.
        if (!q.sync2.cfg_req_n)
        begin
          d.state = ST_RESET;
          d.cnt = 32'h0;
        end
      end
      default:
      begin
        d.state = ST_RESET;
      end
    endcase

    // A low request or an externally held status line forces the reset stage.
    if (q.state != ST_POR && q.state != ST_ERROR && q.state != ST_RESET &&
        (!q.sync2.cfg_req_n || !q.sync2.status_ln))
    begin
      d.state = ST_RESET;
      d.cnt = 32'h0;
    end

    // Register access: read data is captured in the setup cycle.
    d.pslverr = 1'b0;
    if (apb_setup)
    begin
      d.prdata = 32'h0;
      if (i_apb.paddr == REG_CTRL)
      begin
        d.prdata = {29'h0, q.ctrl};
      end
      else if (i_apb.paddr == REG_LENGTH)
      begin
        d.prdata = q.length;
      end
      else if (i_apb.paddr == REG_STATUS)
      begin
        d.prdata = status_word;
      end
      else if (i_apb.paddr == REG_BITCNT)
      begin
        d.prdata = q.bitcnt;
      end
      else
      begin
        d.pslverr = 1'b1;
      end
    end
    else
    begin
      d.pslverr = q.pslverr;
    end
    // Writes land in the access cycle; unmapped writes are dropped.
    if (apb_write)
    begin
      if (i_apb.paddr == REG_CTRL)
      begin
        d.ctrl = i_apb.pwdata[2:0];
      end
      else if (i_apb.paddr == REG_LENGTH)
      begin
        d.length = i_apb.pwdata;
      end
      else if (i_apb.paddr == REG_STATUS && i_apb.pwdata[STAT_ERROR])
      begin
        d.err_flag = 1'b0;
      end
    end
    // Setting the error flag comes last so that it wins over a clear.
    if (q.state == ST_ERROR)
    begin
      d.err_flag = 1'b1;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      q <= '0;
      q.state <= ST_POR;
      q.ctrl <= CTRL_RESET;
      q.length <= LENGTH_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  always_comb
  begin
    // Every access finishes in its first access cycle.
    o_apb.pready = 1'b1;
    o_apb.pslverr = q.pslverr;
    o_apb.prdata = q.prdata;
    o_status_o = 1'b0;
    o_load_complete_o = 1'b0;
    o_init_complete_o = 1'b0;
    // Status low during power-on reset, requested reset and errors.
    o_status_oe_n = !(q.state == ST_POR || q.state == ST_ERROR ||
                      (q.state == ST_RESET && !q.sync2.cfg_req_n));
    o_load_complete_oe_n = (q.state == ST_DONE_WAIT || q.state == ST_INIT_DELAY ||
                            q.state == ST_INIT || q.state == ST_USER);
    o_init_complete_oe_n = !(q.ctrl[CTRL_INIT_DONE_EN] && q.opt_loaded &&
                             (q.state == ST_CONFIG || q.state == ST_DONE_WAIT ||
                              q.state == ST_INIT_DELAY || q.state == ST_INIT));
    o_user_io_hiz = (q.state != ST_USER);
    // Pull-ups stay on through loading and initialisation and drop in user mode.
    o_weak_pullup_en = !q.sync2.pull_dis_n && q.state != ST_POR && q.state != ST_USER;
    o_user_mode = (q.state == ST_USER);
  end

endmodule : pscp_config_port

/* test/pscp_config_port_monitor.sv */
// Purpose: Concurrent checks on the configuration port pins.
// Assumes: One clock domain with a synchronous reset.
// Notes: Bound to the design from the bench top file.
`timescale 1ns/1ns
module pscp_config_port_monitor (
  input wire logic i_clock, // Clock.
  input wire logic i_srst, // Reset.
  input wire pscp_pkg::pscp_apb_rsp_t o_apb, // APB answer.
  input wire logic i_config_req_n, // Request pin.
  input wire logic i_io_pullup_disable_n, // Pull-up disable.
  input wire logic o_status_oe_n, // Status enable.
  input wire logic o_load_complete_oe_n, // Load enable.
  input wire logic o_init_complete_oe_n, // Init enable.
  input wire logic o_user_io_hiz, // I/O off.
  input wire logic o_weak_pullup_en, // Pull-ups.
  input wire logic o_user_mode // User mode.
);
  import pscp_pkg::*;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);
  a_apb_ready: assert property (o_apb.pready)
    else $error("pready low");
  a_por_hold: assert property ($past(i_srst) |-> !o_status_oe_n && !o_load_complete_oe_n)
    else $error("lines not held low");
  a_io_hiz: assert property (!o_user_mode |-> o_user_io_hiz)
    else $error("io driven early");
  a_pullup_off: assert property (i_io_pullup_disable_n [*4] |-> !o_weak_pullup_en)
    else $error("pull-ups on");
  a_user_pullup: assert property (o_user_mode |-> !o_weak_pullup_en)
    else $error("pull-ups in user mode");
  a_req_reset: assert property (!i_config_req_n [*5] |-> !o_load_complete_oe_n && !o_user_mode)
    else $error("not in reset");
  a_init_rel: assert property (!i_config_req_n [*5] |-> o_init_complete_oe_n)
    else $error("init line driven");
  a_user_done: assert property (o_user_mode |-> o_load_complete_oe_n && o_init_complete_oe_n)
    else $error("user mode with lines low");
  a_init_wait: assert property ($rose(o_load_complete_oe_n) |=> !o_user_mode [*8])
    else $error("user mode too soon");
endmodule : pscp_config_port_monitor

/* test/pscp_host_model.sv */
// Purpose: Host that loads the port over the serial link.
// Assumes: Link clock period 160 ns, standing low between frames.
// Notes: Data flips after each bit so a stale level is never sampled.
`timescale 1ns/1ns
module pscp_host_model (
  output logic o_config_req_n, // Request.
  output logic o_sclk, // Serial clock.
  output logic o_sdata // Serial data.
);
  initial
  begin
    o_config_req_n = 1'b0;
    o_sclk = 1'b0;
    o_sdata = 1'b0;
  end
  task automatic restart(input int low_ns);
    #4;
    o_config_req_n = 1'b0;
    #(low_ns);
    o_config_req_n = 1'b1;
  endtask : restart
  task automatic send(input logic [7:0] b);
    #4;
    for (int i = 0; i < 8; i++)
    begin
      o_sdata = b[i];
      #40 o_sclk = 1'b1;
      #80 o_sclk = 1'b0;
      #16 o_sdata = ~b[i];
      #24;
    end
  endtask : send
endmodule : pscp_host_model

/* test/test_pscp_config_port.sv */
// Purpose: Self-checking bench of the configuration port.
// Assumes: Shortened power-on and restart counts.
// Notes: Registers over APB, the serial link by the host model.
`timescale 1ns/1ns
module test_pscp_config_port;
  import pscp_pkg::*;
  logic clock, srst, por_sel, pud, rlu, uclk, uclk_on, req_n, sclk, sdata, err;
  logic st_o, st_oe_n, lc_o, lc_oe_n, ic_o, ic_oe_n, hiz, pu, um, st, lc, ic;
  logic [3:0] scheme;
  logic [31:0] rd;
  int n_mismatch, compares, cyc;
  pscp_apb_req_t req;
  pscp_apb_rsp_t rsp;
  assign st = st_oe_n ? 1'b1 : st_o;
  assign lc = lc_oe_n ? 1'b1 : lc_o;
  assign ic = ic_oe_n ? 1'b1 : ic_o;
  pscp_host_model host_u (.o_config_req_n(req_n), .o_sclk(sclk), .o_sdata(sdata));
  pscp_config_port #(.POR_LONG_CYCLES(20), .POR_SHORT_CYCLES(10), .RESTART_CYCLES(30)) dut_u (
    .i_clock(clock), .i_srst(srst), .i_apb(req), .o_apb(rsp), .i_config_req_n(req_n),
    .i_serial_load_clock(sclk), .i_serial_load_data(sdata), .i_scheme_select(scheme),
    .i_remote_local_update_select(rlu), .i_power_on_delay_select(por_sel), .i_io_pullup_disable_n(pud),
    .i_user_init_clock(uclk), .i_status_i(st), .o_status_o(st_o), .o_status_oe_n(st_oe_n),
    .i_load_complete_i(lc), .o_load_complete_o(lc_o), .o_load_complete_oe_n(lc_oe_n),
    .o_init_complete_o(ic_o), .o_init_complete_oe_n(ic_oe_n), .o_user_io_hiz(hiz),
    .o_weak_pullup_en(pu), .o_user_mode(um));
  task automatic end_sim;
    if (n_mismatch == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock);
    req.penable <= 1'b1;
    do @(posedge clock); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, rd & m, e);
  endtask : rchk
  task automatic wait_um;
    for (int i = 0; i < 5000 && um !== 1'b1; i++) @(posedge clock);
  endtask : wait_um
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always #16 uclk = uclk_on & ~uclk;
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_mismatch++;
      end_sim();
    end
  end
  initial
  begin
    srst = 1'b1;
    req = '0;
    scheme = 4'h0;
    por_sel = 1'b1;
    pud = 1'b0;
    rlu = 1'b1;
    uclk = 1'b0;
    uclk_on = 1'b0;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    rchk("por", REG_STATUS, 32'h7, 32'h0);
    rchk("ctrl", REG_CTRL, 32'h7, {29'h0, CTRL_RESET});
    rchk("length", REG_LENGTH, 32'hffff_ffff, LENGTH_RESET);
    rchk("unmapped", 8'h10, 32'hffff_ffff, 32'h0);
    chk("slverr", err, 1'b1);
    repeat (4) @(posedge clock);
    rchk("por_short", REG_STATUS, 32'h7, 32'h1);
    chk("pullup", pu, 1'b1);
    chk("hiz", hiz, 1'b1);
    apb(1'b1, REG_CTRL, 32'h6);
    apb(1'b1, REG_LENGTH, 32'h10);
    host_u.restart(40000);
    repeat (10) @(posedge clock);
    rchk("bad_scheme", REG_STATUS, 32'h7, 32'h1);
    scheme <= SCHEME_REMOTE;
    repeat (5) @(posedge clock);
    rchk("scheme", REG_STATUS, 32'h67, 32'h62);
    chk("st_rel", st, 1'b1);
    host_u.send(SYNC_BYTE);
    chk("ic_low", ic, 1'b0);
    chk("lc_low", lc, 1'b0);
    host_u.send(8'h3c);
    repeat (10) @(posedge clock);
    chk("lc_high", lc, 1'b1);
    chk("um_early", um, 1'b0);
    wait_um();
    chk("um_osc", um, 1'b1);
    chk("hiz_user", hiz, 1'b0);
    chk("ic_high", ic, 1'b1);
    host_u.send(8'h00);
    chk("um_kept", um, 1'b1);
    @(posedge clock);
    pud <= 1'b1;
    host_u.restart(40000);
    chk("pull_off", pu, 1'b0);
    @(posedge clock);
    pud <= 1'b0;
    repeat (10) @(posedge clock);
    host_u.send(8'h00);
    chk("st_err", st, 1'b0);
    rchk("err", REG_STATUS, 32'h17, 32'h17);
    repeat (40) @(posedge clock);
    chk("st_back", st, 1'b1);
    apb(1'b1, REG_STATUS, 32'h10);
    rchk("w1c", REG_STATUS, 32'h10, 32'h0);
    apb(1'b1, REG_CTRL, 32'h1);
    apb(1'b1, REG_LENGTH, 32'h8);
    uclk_on <= 1'b1;
    host_u.restart(40000);
    repeat (10) @(posedge clock);
    host_u.send(SYNC_BYTE);
    repeat (10) @(posedge clock);
    chk("lc_user", lc, 1'b1);
    repeat (1300) @(posedge clock);
    chk("um_wait", um, 1'b0);
    wait_um();
    chk("um_user", um, 1'b1);
    por_sel <= 1'b0;
    scheme <= SCHEME_PLAIN;
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    repeat (12) @(posedge clock);
    rchk("por_long", REG_STATUS, 32'h7, 32'h0);
    chk("st_por", st, 1'b0);
    repeat (10) @(posedge clock);
    rchk("plain", REG_STATUS, 32'h67, 32'h42);
    scheme <= SCHEME_REMOTE;
    rlu <= 1'b0;
    repeat (5) @(posedge clock);
    rchk("local", REG_STATUS, 32'h67, 32'h42);
    end_sim();
  end
endmodule : test_pscp_config_port
bind pscp_config_port pscp_config_port_monitor mon_u (.i_clock, .i_srst, .o_apb, .i_config_req_n,
  .i_io_pullup_disable_n, .o_status_oe_n, .o_load_complete_oe_n, .o_init_complete_oe_n,
  .o_user_io_hiz, .o_weak_pullup_en, .o_user_mode);
